// ==== rtl/bpr_bank_ctrl.sv ====
// Bank precharge, auto precharge, auto refresh and self refresh control
// ==========================================================
// What this block does
// - Precharge closes the row; bank is usable only after recovery time.
// - All-banks bit low picks one bank by bank selects; high picks all.
// - Precharge to an idle or already precharging bank does nothing.
// - All-banks bit on read/write asks auto precharge after that burst.
// - Auto precharge starts at earliest legal point within row-active time.
// - Read auto precharge starts where an explicit precharge could first go.
// - Early auto precharge waits until minimum row-active time is met.
// - Commands to other banks run during an auto-precharging access.
// - Refresh row comes from an internal counter; address pins ignored.
// - Refresh encoding with clock-enable low enters self refresh.
// - Self refresh covers selected array part at a temperature-set rate.
`timescale 1ns/1ps
`include "bpr_defines.svh"
module bpr_bank_ctrl
  import bpr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mem_clk,
  input wire logic clk_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic all_banks_select_bit,
  input wire logic temp_hot,
  input wire logic [`BPR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [3:0] bank_open,
  output logic self_refresh_active,
  output logic refresh_pulse,
  output logic [`BPR_ROW_W-1:0] refresh_row
);

  // ==========================================================
  // Pin sampling
  logic [8:0] pin_lvl;
  logic ck_lvl, cke_lvl, ck_prev_q, ck_rise;
  logic [1:0] bank_sel;
  bpr_cmd_e cmd;

  bpr_pin_sync #(.W(9)) bpr_pin_sync_inst (
    .clk(clk),
    .reset_n(reset_n),
    .pin({mem_clk, clk_enable, chip_select_n, row_strobe_n, col_strobe_n,
          write_enable_n, bank_select_high, bank_select_low,
          all_banks_select_bit}),
    .level(pin_lvl)
  );

  function automatic bpr_cmd_e decode(input logic [3:0] c);
    case (c)
      4'h7: decode = CMD_NOP;
      4'h3: decode = CMD_ACT;
      4'h5: decode = CMD_READ;
      4'h4: decode = CMD_WRITE;
      4'h2: decode = CMD_PRE;
      4'h1: decode = CMD_REF;
      default: decode = c[3] ? CMD_NOP : CMD_OTHER;
    endcase
  endfunction

  // Data pairs of a burst, in link clock edges
  function automatic logic [3:0] half_burst(input logic [1:0] code);
    half_burst = 4'h1 << code;
  endfunction

  assign ck_lvl = pin_lvl[8];
  assign cke_lvl = pin_lvl[7];
  assign cmd = decode(pin_lvl[6:3]);
  assign bank_sel = pin_lvl[2:1];
  assign ck_rise = ck_lvl & ~ck_prev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_lvl;
    end
  end

  // ==========================================================
  // Configuration register
  logic [`BPR_CFG_W-1:0] cfg_q, cfg_d;
  logic [1:0] bl_code;
  logic [2:0] pasr;

  assign bl_code = cfg_q[`BPR_CFG_BL_MSB:`BPR_CFG_BL_LSB];
  assign pasr = cfg_q[`BPR_CFG_PASR_MSB:`BPR_CFG_PASR_LSB];

  // ==========================================================
  // Refresh control state
  bpr_ref_st_e rst_q, rst_d;
  logic [11:0] rcnt_q, rcnt_d;
  logic [1:0] xedge_q, xedge_d;
  logic [`BPR_ROW_W-1:0] row_q, row_d;
  logic rpulse_q, rpulse_d;
  logic row_in_array;
  logic cmd_live;
  logic all_idle;

  // Bank commands count only on a link edge in normal operation with CKE high
  assign cmd_live = ck_rise & cke_lvl & (rst_q == RF_NORMAL);

  // ==========================================================
  // Per-bank state
  bpr_bank_st_e bank_q [4];
  bpr_bank_st_e bank_d [4];
  logic [7:0] ras_q [4];
  logic [7:0] ras_d [4];
  logic [7:0] cnt_q [4];
  logic [7:0] cnt_d [4];
  logic [3:0] edge_q [4];
  logic [3:0] edge_d [4];
  logic [3:0] wr_q, wr_d;
  logic [3:0] open_vec, idle_vec;

  always_comb begin
    bank_d = bank_q;
    ras_d = ras_q;
    cnt_d = cnt_q;
    edge_d = edge_q;
    wr_d = wr_q;
    for (int b = 0; b < 4; b++) begin
      if (ras_q[b] != 8'h00) begin
        ras_d[b] = ras_q[b] - 8'h01;
      end
      case (bank_q[b])
        BK_AP_BURST: begin
          if (ck_rise) begin
            if (edge_q[b] <= 4'h1) begin
              if (wr_q[b]) begin
                bank_d[b] = BK_AP_WREC;
                cnt_d[b] = 8'(`BPR_WR_CYC - 1);
              end else begin
                bank_d[b] = BK_AP_WAIT;
              end
            end else begin
              edge_d[b] = edge_q[b] - 4'h1;
            end
          end
        end
        BK_AP_WREC: begin
          if (cnt_q[b] == 8'h00) begin
            bank_d[b] = BK_AP_WAIT;
          end else begin
            cnt_d[b] = cnt_q[b] - 8'h01;
          end
        end
        BK_AP_WAIT: begin
          // Lock-out: hold the precharge until row-active time is met
          if (ras_q[b] == 8'h00) begin
            bank_d[b] = BK_PRECHG;
            cnt_d[b] = 8'(`BPR_RP_CYC - 1);
          end
        end
        BK_PRECHG: begin
          if (cnt_q[b] == 8'h00) begin
            bank_d[b] = BK_IDLE;
          end else begin
            cnt_d[b] = cnt_q[b] - 8'h01;
          end
        end
        default: begin
        end
      endcase
      // Commands touch only the addressed bank, or every active bank on precharge all; others keep running
      if (cmd_live) begin
        case (cmd)
          CMD_ACT: begin
            if (bank_sel == 2'(b) && bank_q[b] == BK_IDLE) begin
              bank_d[b] = BK_ACTIVE;
              ras_d[b] = 8'(`BPR_RAS_CYC - 1);
            end
          end
          CMD_READ, CMD_WRITE: begin
            if (bank_sel == 2'(b) && bank_q[b] == BK_ACTIVE &&
                pin_lvl[0]) begin
              bank_d[b] = BK_AP_BURST;
              wr_d[b] = (cmd == CMD_WRITE);
              // Write: one extra edge on top of the read count for the same burst
              edge_d[b] = (cmd == CMD_WRITE) ?
                          half_burst(bl_code) + 4'h1 : half_burst(bl_code);
            end
          end
          CMD_PRE: begin
            // Idle or already closing banks ignore it
            if ((pin_lvl[0] || bank_sel == 2'(b)) &&
                bank_q[b] == BK_ACTIVE) begin
              bank_d[b] = BK_PRECHG;
              cnt_d[b] = 8'(`BPR_RP_CYC - 1);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < 4; b++) begin
        bank_q[b] <= BK_IDLE;
        ras_q[b] <= 8'h00;
        cnt_q[b] <= 8'h00;
        edge_q[b] <= 4'h0;
      end
      wr_q <= 4'h0;
    end else begin
      bank_q <= bank_d;
      ras_q <= ras_d;
      cnt_q <= cnt_d;
      edge_q <= edge_d;
      wr_q <= wr_d;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      idle_vec[b] = (bank_q[b] == BK_IDLE);
      open_vec[b] = (bank_q[b] == BK_ACTIVE) || (bank_q[b] == BK_AP_BURST);
    end
  end
  assign all_idle = &idle_vec;

  // ==========================================================
  // Refresh sequencing
  always_comb begin
    case (pasr)
      `BPR_PASR_HALF: row_in_array = ~row_q[`BPR_ROW_W-1];
      `BPR_PASR_QUARTER: row_in_array = (row_q[`BPR_ROW_W-1 -: 2] == 2'h0);
      default: row_in_array = 1'b1;
    endcase
  end

  always_comb begin
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    xedge_d = xedge_q;
    row_d = row_q;
    rpulse_d = 1'b0;
    case (rst_q)
      RF_NORMAL: begin
        // Address pins are not looked at for refresh
        if (ck_rise && cmd == CMD_REF && all_idle) begin
          rpulse_d = 1'b1;
          row_d = row_q + 1'b1;
          if (cke_lvl) begin
            rst_d = RF_AUTO;
            rcnt_d = 12'(`BPR_RFC_CYC - 1);
          end else begin
            rst_d = RF_SELF;
            rcnt_d = 12'(`BPR_TICK_CYC - 1);
          end
        end
      end
      RF_AUTO: begin
        if (rcnt_q == 12'h000) begin
          rst_d = RF_NORMAL;
        end else begin
          rcnt_d = rcnt_q - 12'h001;
        end
      end
      RF_SELF: begin
        // Pins other than CKE are ignored here
        if (cke_lvl) begin
          rst_d = RF_EXIT;
          rcnt_d = 12'(`BPR_XSR_CYC - 1);
          xedge_d = 2'h0;
        end else if (rcnt_q == 12'h000) begin
          // Warm array leaks faster, so tick twice as often
          rcnt_d = temp_hot ? 12'(`BPR_TICK_CYC / 2 - 1)
                            : 12'(`BPR_TICK_CYC - 1);
          rpulse_d = row_in_array;
          row_d = row_q + 1'b1;
        end else begin
          rcnt_d = rcnt_q - 12'h001;
        end
      end
      RF_EXIT: begin
        if (rcnt_q != 12'h000) begin
          rcnt_d = rcnt_q - 12'h001;
        end
        if (ck_rise && xedge_q != 2'h3) begin
          xedge_d = xedge_q + 2'h1;
        end
        if (rcnt_q == 12'h000 && xedge_q >= 2'(`BPR_XSR_MIN_EDGES)) begin
          rst_d = RF_NORMAL;
        end
      end
      default: rst_d = RF_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= RF_NORMAL;
      rcnt_q <= 12'h000;
      xedge_q <= 2'h0;
      row_q <= '0;
      rpulse_q <= 1'b0;
    end else begin
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
      xedge_q <= xedge_d;
      row_q <= row_d;
      rpulse_q <= rpulse_d;
    end
  end

  // ==========================================================
  // Register port and outputs
  logic [31:0] rdata_d, rdata_q, status;
  logic [3:0] open_q;
  logic sref_q;

  always_comb begin
    status = 32'h0;
    status[`BPR_ST_OPEN_LSB +: 4] = open_vec;
    status[`BPR_ST_IDLE_LSB +: 4] = idle_vec;
    status[`BPR_ST_REF_LSB +: 2] = rst_q;
  end

  always_comb begin
    cfg_d = cfg_q;
    rdata_d = 32'h0;
    if (reg_write && reg_addr == `BPR_REG_CONFIG) begin
      cfg_d = reg_wdata[`BPR_CFG_W-1:0];
    end
    if (reg_read) begin
      case (reg_addr)
        `BPR_REG_CONFIG: rdata_d = {27'h0, cfg_q};
        `BPR_REG_STATUS: rdata_d = status;
        `BPR_REG_ROW: rdata_d = {18'h0, row_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `BPR_CFG_RESET;
      rdata_q <= 32'h0;
      open_q <= 4'h0;
      sref_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      open_q <= open_vec;
      sref_q <= (rst_q == RF_SELF);
    end
  end

  assign reg_rdata = rdata_q;
  assign bank_open = open_q;
  assign self_refresh_active = sref_q;
  assign refresh_pulse = rpulse_q;
  assign refresh_row = row_q;

endmodule

// ==== rtl/bpr_defines.svh ====
// Offsets, field positions, reset values and timing counts of the block
`ifndef BPR_DEFINES_SVH
`define BPR_DEFINES_SVH

// ==========================================================
// Clock
`define BPR_CLK_PERIOD_NS 8

// ==========================================================
// Array timing, in ns (plain defaults)
`define BPR_T_PRECHARGE_RECOVERY_NS 15
`define BPR_T_ROW_ACTIVE_MIN_NS 40
`define BPR_T_WRITE_RECOVERY_NS 15
`define BPR_T_REFRESH_CYCLE_NS 72
`define BPR_T_SELF_REFRESH_EXIT_NS 112
`define BPR_T_SELF_REFRESH_TICK_NS 7800

// Least times round up to whole clock cycles
`define BPR_CYC_UP(ns) (((ns) + `BPR_CLK_PERIOD_NS - 1) / `BPR_CLK_PERIOD_NS)
`define BPR_RP_CYC `BPR_CYC_UP(`BPR_T_PRECHARGE_RECOVERY_NS)
`define BPR_RAS_CYC `BPR_CYC_UP(`BPR_T_ROW_ACTIVE_MIN_NS)
`define BPR_WR_CYC `BPR_CYC_UP(`BPR_T_WRITE_RECOVERY_NS)
`define BPR_RFC_CYC `BPR_CYC_UP(`BPR_T_REFRESH_CYCLE_NS)
`define BPR_XSR_CYC `BPR_CYC_UP(`BPR_T_SELF_REFRESH_EXIT_NS)
// Longest interval rounds down
`define BPR_TICK_CYC (`BPR_T_SELF_REFRESH_TICK_NS / `BPR_CLK_PERIOD_NS)
`define BPR_XSR_MIN_EDGES 2

// ==========================================================
// Widths
`define BPR_ROW_W 14
`define BPR_ADDR_W 4

// ==========================================================
// Register offsets (byte addresses)
`define BPR_REG_CONFIG 4'h0
`define BPR_REG_STATUS 4'h4
`define BPR_REG_ROW 4'h8

// Config fields and reset value
`define BPR_CFG_BL_LSB 0
`define BPR_CFG_BL_MSB 1
`define BPR_CFG_PASR_LSB 2
`define BPR_CFG_PASR_MSB 4
`define BPR_CFG_W 5
`define BPR_CFG_RESET 5'h01

// Status fields
`define BPR_ST_OPEN_LSB 0
`define BPR_ST_IDLE_LSB 4
`define BPR_ST_REF_LSB 8

// Partial-array codes
`define BPR_PASR_HALF 3'h1
`define BPR_PASR_QUARTER 3'h2

`endif

// ==== rtl/bpr_pkg.sv ====
// Types shared by the bank precharge and refresh control
package bpr_pkg;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVE, BK_AP_BURST, BK_AP_WREC, BK_AP_WAIT, BK_PRECHG
  } bpr_bank_st_e;

  typedef enum logic [1:0] {
    RF_NORMAL, RF_AUTO, RF_SELF, RF_EXIT
  } bpr_ref_st_e;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_OTHER
  } bpr_cmd_e;

endpackage

// ==== rtl/bpr_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module bpr_pin_sync #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // A change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule

// ==== sim/bpr_bank_ctrl_asserts.sv ====
// Port checker for the bank precharge and refresh control
`timescale 1ns/1ps
`include "bpr_defines.svh"
module bpr_bank_ctrl_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] bank_open,
  input wire logic self_refresh_active,
  input wire logic refresh_pulse,
  input wire logic [`BPR_ROW_W-1:0] refresh_row
);
  // ==========
  // Pins reach bank state about six clocks after a link edge
  wire [3:0] cmd_w;
  assign cmd_w = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_open_by_act;
    (bank_open & ~$past(bank_open)) != 4'h0 |-> $past(cmd_w, 6) == 4'h3;
  endproperty
  a_open_by_act: assert property (p_open_by_act)
    else $error("bank opened without activate");
  property p_self_entry;
    $rose(self_refresh_active) |-> !$past(clk_enable, 6) &&
      $past(cmd_w, 6) == 4'h1;
  endproperty
  a_self_entry: assert property (p_self_entry)
    else $error("self refresh entered without its command");
  property p_self_exit;
    $fell(self_refresh_active) |-> $past(clk_enable, 2);
  endproperty
  a_self_exit: assert property (p_self_exit)
    else $error("self refresh left with clock enable low");
  property p_self_idle;
    self_refresh_active |-> bank_open == 4'h0;
  endproperty
  a_self_idle: assert property (p_self_idle)
    else $error("bank open during self refresh");
  property p_pulse_gap;
    refresh_pulse |=> (!refresh_pulse) [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("refresh pulses too close");
  property p_row_step;
    refresh_row != $past(refresh_row) |->
      refresh_row == $past(refresh_row) + 1'b1;
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("refresh row did not step by one");
  property p_auto_busy;
    refresh_pulse && !self_refresh_active |=> (bank_open == 4'h0) [*8];
  endproperty
  a_auto_busy: assert property (p_auto_busy)
    else $error("bank opened inside refresh cycle");
  property p_rdata_quiet;
    !$past(reg_read) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside its cycle");
endmodule

bind bpr_bank_ctrl bpr_bank_ctrl_asserts bpr_bank_ctrl_asserts_inst (
  .clk, .reset_n, .clk_enable, .chip_select_n, .row_strobe_n,
  .col_strobe_n, .write_enable_n, .reg_read, .reg_rdata, .bank_open,
  .self_refresh_active, .refresh_pulse, .refresh_row);

// ==== sim/bpr_mem_ctrl_model.sv ====
// Memory controller model: link clock and command pins
`timescale 1ns/1ps
module bpr_mem_ctrl_model (
  input wire logic clk,
  output logic mem_clk,
  output logic clk_enable,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic all_banks_select_bit
);
  // ==========
  // Free running, so the clock is stable before any exit
  initial begin
    mem_clk = 1'b0;
    clk_enable = 1'b1;
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'h7;
    {bank_select_high, bank_select_low, all_banks_select_bit} = 3'h0;
  end
  always #62.5 mem_clk = ~mem_clk;

  // ==========
  // Pins move after a falling link edge, settled around the rise
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank,
    input logic a10, input logic cke, input int idle);
    @(negedge mem_clk);
    @(posedge clk);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= cmd;
    {bank_select_high, bank_select_low} <= bank;
    all_banks_select_bit <= a10;
    clk_enable <= cke;
    @(negedge mem_clk);
    @(posedge clk);
    chip_select_n <= 1'b1;
    // Deselected lines carry the inverse so stale values never pass
    {bank_select_high, bank_select_low} <= ~bank;
    all_banks_select_bit <= ~a10;
    repeat (idle) @(negedge mem_clk);
  endtask
endmodule

// ==== sim/bpr_bank_ctrl_tb_top.sv ====
// Self-checking bench for the bank precharge and refresh control
`timescale 1ns/1ps
`include "bpr_defines.svh"
module bpr_bank_ctrl_tb_top;
  localparam logic [3:0] C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2, C_REF = 4'h1, C_NOP = 4'h7;
  logic clk, reset_n, mem_clk, clk_enable, temp_hot, reg_write, reg_read;
  logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
  logic bank_select_low, bank_select_high, all_banks_select_bit;
  logic self_refresh_active, refresh_pulse;
  logic [`BPR_ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0] bank_open;
  logic [`BPR_ROW_W-1:0] refresh_row;
  int num_errors, num_checks, seed, exp_open, exp_row, pulses, b, r0, p0;

  bpr_bank_ctrl bpr_bank_ctrl_inst (.clk, .reset_n, .mem_clk, .clk_enable,
    .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
    .bank_select_low, .bank_select_high, .all_banks_select_bit, .temp_hot,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .bank_open,
    .self_refresh_active, .refresh_pulse, .refresh_row);
  bpr_mem_ctrl_model bpr_mem_ctrl_model_inst (.clk, .mem_clk, .clk_enable,
    .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
    .bank_select_low, .bank_select_high, .all_banks_select_bit);

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) if (refresh_pulse === 1'b1) pulses++;

  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic settle(input int edges);
    repeat (edges) @(posedge mem_clk);
    repeat (10) @(posedge clk);
    #1;
  endtask
  // Model updates at once; bank state is compared after settling
  task automatic do_cmd(input logic [3:0] c, input int bk, input logic a10,
    input int edges);
    bpr_mem_ctrl_model_inst.issue(c, bk[1:0], a10, 1'b1,
      (c == C_REF) ? 2 : 0);
    if (c == C_ACT) exp_open |= 1 << bk;
    if (c == C_PRE) exp_open &= a10 ? 0 : ~(1 << bk);
    if ((c == C_RD || c == C_WR) && a10) exp_open &= ~(1 << bk);
    if (c == C_REF && exp_open == 0) exp_row++;
    if (edges > 0) begin
      settle(edges);
      check("bank_open", bank_open, exp_open);
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    seed = 22418;
    reset_n = 1'b0;
    temp_hot = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    reg_rd(4'h0, d);
    check("config", d, 32'h1);
    reg_wr(4'h4, 32'h3ff);
    reg_wr(4'hc, 32'h3);
    reg_rd(4'h4, d);
    check("status", d, 32'hf0);
    reg_rd(4'hc, d);
    check("unmapped", d, 32'h0);
    b = $random(seed) & 3;
    do_cmd(C_ACT, b, 1'b0, 1);
    do_cmd(C_PRE, b ^ 1, 1'b0, 1);
    do_cmd(C_REF, b, 1'b1, 1);
    do_cmd(C_PRE, b, 1'b0, 1);
    do_cmd(C_PRE, b, 1'b0, 1);
    for (int i = 0; i < 4; i++) do_cmd(C_ACT, i, 1'b0, 0);
    do_cmd(C_PRE, $random(seed) & 3, 1'b1, 1);
    for (int i = 0; i < 4; i++) begin
      do_cmd(C_ACT, i, 1'b0, 0);
      do_cmd((i & 1) ? C_WR : C_RD, i, 1'b0, 1);
      do_cmd((i & 1) ? C_WR : C_RD, i, 1'b1, 4);
    end
    reg_wr(4'h0, 32'h3);
    do_cmd(C_ACT, 2, 1'b0, 0);
    do_cmd(C_RD, 2, 1'b1, 0);
    settle(2);
    check("long burst", bank_open[2], 1'b1);
    settle(8);
    check("long burst", bank_open[2], 1'b0);
    reg_wr(4'h0, 32'h1);
    do_cmd(C_ACT, 0, 1'b0, 0);
    do_cmd(C_WR, 0, 1'b1, 0);
    do_cmd(C_ACT, 3, 1'b0, 4);
    do_cmd(C_PRE, 0, 1'b1, 1);
    p0 = pulses;
    do_cmd(C_REF, $random(seed) & 3, 1'($random(seed)), 1);
    check("row", refresh_row, exp_row);
    check("pulses", pulses - p0, 1);
    reg_rd(4'h8, d);
    check("row reg", d, exp_row);
    @(posedge clk);
    temp_hot <= 1'b1;
    r0 = refresh_row;
    p0 = pulses;
    bpr_mem_ctrl_model_inst.issue(C_REF, 2'h1, 1'b0, 1'b0, 0);
    settle(0);
    check("self", self_refresh_active, 1'b1);
    bpr_mem_ctrl_model_inst.issue(C_ACT, 2'h2, 1'b0, 1'b0, 0);
    repeat (2000) @(posedge clk);
    check("ignored", bank_open, 4'h0);
    reg_rd(4'h4, d);
    check("state", d[9:8], 2'h2);
    check("ticks", (refresh_row - r0) inside {[3:5]}, 1'b1);
    check("self pulses", pulses - p0, refresh_row - r0);
    bpr_mem_ctrl_model_inst.issue(C_NOP, 2'h0, 1'b0, 1'b1, 2);
    settle(1);
    check("exit", self_refresh_active, 1'b0);
    reg_rd(4'h4, d);
    check("normal", d[9:8], 2'h0);
    // Self ticks vary with time, so resync the row model after exit
    r0 = refresh_row;
    exp_row = r0;
    p0 = pulses;
    do_cmd(C_REF, $random(seed) & 3, 1'b0, 1);
    check("row after exit", refresh_row, exp_row);
    check("pulse after exit", pulses - p0, 1);
    report_and_stop();
  end

  initial begin
    #700000;
    num_errors++;
    report_and_stop();
  end
endmodule
